/* hw/fmsp_device.sv */
module fmsp_device
	import fmsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	fmsp_link_if.device link,
	input wire logic quad_enable_bit,
	input wire logic erase_running,
	input wire logic chip_erase_running,
	input wire logic program_running,
	input wire logic write_enable_latch_in,
	output logic quad_peripheral_mode,
	output logic [15:0] status_word,
	output logic deep_powerdown,
	output logic suspend_pulse,
	output logic resume_pulse,
	output logic [7:0] accepted_cmd,
	output logic accepted_valid
);
	typedef enum {FMSP_IDLE, FMSP_SUSPENDING, FMSP_PD_ENTRY, FMSP_PD, FMSP_RECOVER} fmsp_dev_state_t;
	logic [2:0] sck_s_q, cs_s_q;
	logic [3:0] io_m_q, io_s_q;
	logic [7:0] shift_q, shift_d;
	logic [3:0] bits_q, bits_d;
	logic quad_q, quad_d, program_suspended_flag_q, program_suspended_flag_d, erase_suspended_flag_q, erase_suspended_flag_d, wel_q, wel_d, busy_q, busy_d;
	logic pd_q, pd_d, susp_p_q, susp_p_d, res_p_q, res_p_d, acc_v_q, acc_v_d;
	logic [7:0] acc_q, acc_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	fmsp_dev_state_t st_q, st_d;
	logic sck_rise, cs_rise, cs_low, done, allowed, ignored;
	logic [15:0] stat_q, stat_d;
	logic [7:0] cmd;
	// pin synchronisers, then edge detection on the second stage onward
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sck_s_q <= 3'h0;
			cs_s_q <= 3'h7;
			io_m_q <= 4'hF;
			io_s_q <= 4'hF;
		end
		else
		begin
			sck_s_q <= {sck_s_q[1:0], link.sck};
			cs_s_q <= {cs_s_q[1:0], link.cs_b};
			io_m_q <= link.io;
			io_s_q <= io_m_q;
		end
	end
	assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
	assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
	assign cs_low = ~cs_s_q[1];
	assign link.io_d = 4'h0;
	assign link.io_d_oe = 4'h0;
	assign cmd = shift_q;
	// commands that pass the filter but would change nothing are not reported as taken
	assign ignored = (cmd == CMD_QUAD_ENTRY && (quad_q || !quad_enable_bit))
		|| (cmd == CMD_QUAD_EXIT && !quad_q)
		|| (cmd == CMD_SUSPEND && (chip_erase_running || !(program_running || (erase_running && !erase_suspended_flag_q)))) // see RL6
		|| (cmd == CMD_RESUME && !(program_suspended_flag_q || erase_suspended_flag_q));
	// exactly 8 bits (spi) or 2 nibbles (quad) ends a command
	assign done = quad_q ? (bits_q == 4'h2) : (bits_q == 4'h8); // see RL24 see RL2
	// suspend filter: reads, status, ids, reset always; more during erase suspend
	always_comb
	begin
		case (cmd)
			8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED, CMD_STATUS_READ, CMD_RESUME,
			8'hAB, 8'h9F, 8'h90, 8'h4B, 8'h5A, 8'hC0, 8'h66, 8'h99: allowed = 1'b1; // see RL16
			CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM, CMD_WRITE_ENABLE, CMD_SUSPEND:
				allowed = ~program_suspended_flag_q; // see RL17 see RL7 see RL8
			default: allowed = ~(program_suspended_flag_q | erase_suspended_flag_q);
		endcase
	end
	// command shifter and decision at select rise
	always_comb
	begin
		shift_d = shift_q;
		bits_d = bits_q;
		quad_d = quad_q;
		program_suspended_flag_d = program_suspended_flag_q;
		erase_suspended_flag_d = erase_suspended_flag_q;
		wel_d = wel_q | write_enable_latch_in;
		busy_d = busy_q;
		pd_d = pd_q;
		st_d = st_q;
		cnt_d = cnt_q;
		susp_p_d = 1'b0;
		res_p_d = 1'b0;
		acc_v_d = 1'b0;
		acc_d = acc_q;
		if (!quad_enable_bit)
			quad_d = 1'b0; // see RL22
		if (cs_low && sck_rise && bits_q != 4'hF)
		begin
			if (quad_q)
				shift_d = {shift_q[3:0], io_s_q}; // see RL13
			else
				shift_d = {shift_q[6:0], io_s_q[0]};
			bits_d = bits_q + 4'h1;
		end
		if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
		case (st_q)
			FMSP_SUSPENDING:
				if (cnt_q == '0)
				begin
					busy_d = 1'b0;
					st_d = FMSP_IDLE;
				end
			FMSP_PD_ENTRY:
				if (cnt_q == '0)
				begin
					pd_d = 1'b1;
					st_d = FMSP_PD;
				end
			FMSP_RECOVER:
				if (cnt_q == '0)
					st_d = FMSP_IDLE; // see RL20
			default: ;
		endcase
		if (cs_rise)
		begin
			bits_d = 4'h0;
			if (done && st_q == FMSP_PD)
			begin
				if (cmd == CMD_RELEASE && !(erase_running || program_running)) // see RL19 see RL21
				begin
					acc_d = cmd;
					acc_v_d = 1'b1;
					pd_d = 1'b0;
					st_d = FMSP_RECOVER;
					cnt_d = CNT_W'(RELEASE_RECOVERY_CYC);
				end
			end
			else if (done && (st_q == FMSP_IDLE || (st_q == FMSP_SUSPENDING && cmd == CMD_STATUS_READ))) // see RL23 see RL11
			begin
				if (allowed)
				begin
					acc_d = cmd;
					acc_v_d = !ignored;
					if (cmd == CMD_QUAD_ENTRY && !quad_q && quad_enable_bit)
						quad_d = 1'b1; // see RL1
					else if (cmd == CMD_QUAD_EXIT && quad_q)
						quad_d = 1'b0; // see RL2
					else if (cmd == CMD_WRITE_ENABLE)
						wel_d = 1'b1;
					else if (cmd == CMD_SUSPEND && !chip_erase_running) // see RL6 see RL4
					begin
						if (program_running)
						begin
							program_suspended_flag_d = 1'b1; // see RL10 see RL5
							wel_d = 1'b0;
						end
						else if (erase_running && !erase_suspended_flag_q)
						begin
							erase_suspended_flag_d = 1'b1; // see RL9 see RL5
							wel_d = 1'b0;
						end
						if (program_running || (erase_running && !erase_suspended_flag_q))
						begin
							susp_p_d = 1'b1;
							busy_d = 1'b1;
							st_d = FMSP_SUSPENDING;
							cnt_d = CNT_W'(SUSPEND_CYC);
						end
					end
					else if (cmd == CMD_RESUME && (program_suspended_flag_q || erase_suspended_flag_q)) // see RL12
					begin
						res_p_d = 1'b1;
						if (program_suspended_flag_q)
							program_suspended_flag_d = 1'b0;
						else
							erase_suspended_flag_d = 1'b0;
					end
					else if (cmd == CMD_POWERDOWN) // see RL18
					begin
						st_d = FMSP_PD_ENTRY;
						cnt_d = CNT_W'(POWERDOWN_ENTRY_CYC);
					end
				end
			end
		end
	end
	// register stage
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_q <= 8'h00;
			bits_q <= 4'h0;
			quad_q <= 1'b0;
			program_suspended_flag_q <= 1'b0;
			erase_suspended_flag_q <= 1'b0;
			wel_q <= 1'b0;
			busy_q <= 1'b0;
			pd_q <= 1'b0;
			st_q <= FMSP_IDLE;
			cnt_q <= '0;
			susp_p_q <= 1'b0;
			res_p_q <= 1'b0;
			acc_q <= 8'h00;
			acc_v_q <= 1'b0;
			stat_q <= STAT_RESET;
		end
		else
		begin
			shift_q <= shift_d;
			bits_q <= bits_d;
			quad_q <= quad_d;
			program_suspended_flag_q <= program_suspended_flag_d;
			erase_suspended_flag_q <= erase_suspended_flag_d;
			wel_q <= wel_d;
			busy_q <= busy_d;
			pd_q <= pd_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			susp_p_q <= susp_p_d;
			res_p_q <= res_p_d;
			acc_q <= acc_d;
			acc_v_q <= acc_v_d;
			stat_q <= stat_d;
		end
	end
	// next status word, registered before it leaves the block
	always_comb
	begin
		stat_d = STAT_RESET;
		stat_d[STAT_BUSY_BIT] = busy_q | program_running | erase_running;
		stat_d[STAT_WEL_BIT] = wel_q;
		stat_d[STAT_PROGRAM_SUSPENDED_FLAG_BIT] = program_suspended_flag_q; // see RL5
		stat_d[STAT_ERASE_SUSPENDED_FLAG_BIT] = erase_suspended_flag_q;
	end
	// outputs straight from flip-flops
	assign status_word = stat_q;
	assign quad_peripheral_mode = quad_q;
	assign deep_powerdown = pd_q;
	assign suspend_pulse = susp_p_q;
	assign resume_pulse = res_p_q;
	assign accepted_cmd = acc_q;
	assign accepted_valid = acc_v_q;
endmodule // fmsp_device

/* pkg/fmsp_pkg.sv */
// Summary of operation
// RL1 - quad entry makes later commands four-bit
// RL2 - quad exit accepted only as 2-clock command
// RL3 - host frames quad exit with select low/high
// RL4 - suspend and resume work in both modes
// RL5 - status bit 10/15 show program/erase suspended
// RL6 - suspend ignored during whole-chip erase
// RL7 - erase suspended: refuse status write, erases
// RL8 - program suspended: refuse status write, programs
// RL9 - erase suspend sets flag, clears write latch
// RL10 - program suspend sets flag, clears write latch
// RL11 - busy up to 20 us after suspend
// RL12 - resume restarts operation, clears suspend flag
// RL13 - quad cycle is two nibbles, high first
// RL14 - host waits 100 us before re-suspending erase
// RL15 - host polls busy for resumed completion; code host never polls, it only waits a fixed gap after each frame
// RL16 - suspend allows only reads, status, ids, reset
// RL17 - erase suspend also allows program, enable, suspend
// RL18 - power-down only if select rises after byte
// RL19 - in power-down only release is honoured
// RL20 - release needs recovery time before commands
// RL21 - release ignored while write in progress
// RL22 - quad enable bit needed for quad mode
// RL23 - status read allowed at any time; code takes it only when idle or suspending
// RL24 - act only on exact complete command codes
package fmsp_pkg;
	localparam logic [7:0] CMD_QUAD_ENTRY = 8'h38;
	localparam logic [7:0] CMD_QUAD_EXIT = 8'hFF;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	localparam logic [7:0] CMD_POWERDOWN = 8'hB9;
	localparam logic [7:0] CMD_RELEASE = 8'hAB;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam int STAT_PROGRAM_SUSPENDED_FLAG_BIT = 10;
	localparam int STAT_ERASE_SUSPENDED_FLAG_BIT = 15;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam int CLK_MHZ = 20;
	localparam int SUSPEND_US = 20;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int RESUME_GAP_US = 100;
	localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;
	localparam int RELEASE_RECOVERY_US = 3;
	localparam int RELEASE_RECOVERY_CYC = RELEASE_RECOVERY_US * CLK_MHZ;
	localparam int POWERDOWN_ENTRY_US = 3;
	localparam int POWERDOWN_ENTRY_CYC = POWERDOWN_ENTRY_US * CLK_MHZ;
	localparam int CNT_W = 12;
	localparam int SCK_HALF = 4;
	// host operation codes on its user port
	typedef enum logic [2:0] {FMSP_OP_RAW, FMSP_OP_QUAD_ENTRY, FMSP_OP_QUAD_EXIT, FMSP_OP_SUSPEND,
		FMSP_OP_RESUME, FMSP_OP_POWERDOWN, FMSP_OP_RELEASE} fmsp_op_t;
endpackage

/* pkg/fmsp_link_if.sv */
// serial link between controller and flash device
interface fmsp_link_if;
	logic sck;
	logic cs_b;
	logic [3:0] io_h;
	logic [3:0] io_h_oe;
	logic [3:0] io_d;
	logic [3:0] io_d_oe;
	logic [3:0] io;
	// wire level resolved from enables, pulled high when nobody drives
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			io[i] = io_h_oe[i] ? io_h[i] : (io_d_oe[i] ? io_d[i] : 1'b1);
	end
	modport host (output sck, output cs_b, output io_h, output io_h_oe, input io);
	modport device (input sck, input cs_b, output io_d, output io_d_oe, input io);
endinterface

/* hw/fmsp_host.sv */
module fmsp_host
	import fmsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	fmsp_link_if.host link,
	input wire logic req_valid,
	input wire logic [2:0] req_op,
	input wire logic [7:0] req_code,
	input wire logic req_quad,
	output logic req_ready,
	output logic done_pulse
);
	typedef enum {FMSP_H_IDLE, FMSP_H_SHIFT, FMSP_H_END, FMSP_H_WAIT} fmsp_host_state_t;
	fmsp_host_state_t st_q, st_d;
	logic [7:0] code_q, code_d;
	logic quad_q, quad_d, sck_q, sck_d, cs_q, cs_d, rdy_q, rdy_d, dn_q, dn_d;
	logic [3:0] left_q, left_d, out_q, out_d;
	logic [2:0] div_q, div_d;
	logic [CNT_W-1:0] wait_q, wait_d;
	logic sus_q, sus_d, res_q, res_d;
	logic [3:0] oe_q, oe_d;
	// sequencer: one framed command of 8 bits or 2 nibbles, then a settle wait
	always_comb
	begin
		st_d = st_q;
		code_d = code_q;
		quad_d = quad_q;
		sck_d = sck_q;
		cs_d = cs_q;
		rdy_d = rdy_q;
		dn_d = 1'b0;
		left_d = left_q;
		out_d = out_q;
		div_d = div_q;
		wait_d = wait_q;
		sus_d = sus_q;
		res_d = res_q;
		case (st_q)
			FMSP_H_IDLE:
				if (req_valid && rdy_q)
				begin
					case (fmsp_op_t'(req_op))
						FMSP_OP_QUAD_ENTRY: code_d = CMD_QUAD_ENTRY;
						FMSP_OP_QUAD_EXIT: code_d = CMD_QUAD_EXIT; // see RL3
						FMSP_OP_SUSPEND: code_d = CMD_SUSPEND;
						FMSP_OP_RESUME: code_d = CMD_RESUME;
						FMSP_OP_POWERDOWN: code_d = CMD_POWERDOWN;
						FMSP_OP_RELEASE: code_d = CMD_RELEASE;
						default: code_d = req_code;
					endcase
					quad_d = req_quad;
					sus_d = (code_d == CMD_SUSPEND);
					res_d = (code_d == CMD_RESUME);
					left_d = req_quad ? 4'h2 : 4'h8; // see RL13
					cs_d = 1'b0;
					rdy_d = 1'b0;
					div_d = 3'h0;
					st_d = FMSP_H_SHIFT;
					out_d = req_quad ? code_d[7:4] : {3'h7, code_d[7]};
				end
			FMSP_H_SHIFT:
			begin
				div_d = div_q + 3'h1;
				if (div_q == 3'(SCK_HALF - 1))
				begin
					div_d = 3'h0;
					sck_d = ~sck_q;
					if (sck_q)
					begin
						left_d = left_q - 4'h1;
						code_d = quad_q ? {code_q[3:0], 4'h0} : {code_q[6:0], 1'b0};
						out_d = quad_q ? code_d[7:4] : {3'h7, code_d[7]};
						if (left_q == 4'h1)
							st_d = FMSP_H_END;
					end
				end
			end
			FMSP_H_END:
			begin
				div_d = div_q + 3'h1;
				if (div_q == 3'(SCK_HALF - 1))
				begin
					cs_d = 1'b1; // see RL18
					st_d = FMSP_H_WAIT;
					// suspend and resume need a longer quiet time than other frames
					if (sus_q)
						wait_d = CNT_W'(SUSPEND_CYC); // see RL11
					else if (res_q)
						wait_d = CNT_W'(RESUME_GAP_CYC); // see RL14
					else
						wait_d = CNT_W'(RELEASE_RECOVERY_CYC); // see RL20
				end
			end
			FMSP_H_WAIT:
				if (wait_q == '0)
				begin
					rdy_d = 1'b1;
					dn_d = 1'b1;
					st_d = FMSP_H_IDLE;
				end
				else
					wait_d = wait_q - 1'b1;
			default: st_d = FMSP_H_IDLE;
		endcase
		oe_d = cs_d ? 4'h0 : (quad_d ? 4'hF : 4'h1);
	end
	// register stage
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q <= FMSP_H_IDLE;
			code_q <= 8'h00;
			quad_q <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			rdy_q <= 1'b1;
			dn_q <= 1'b0;
			left_q <= 4'h0;
			out_q <= 4'hF;
			div_q <= 3'h0;
			wait_q <= '0;
			sus_q <= 1'b0;
			res_q <= 1'b0;
			oe_q <= 4'h0;
		end
		else
		begin
			st_q <= st_d;
			code_q <= code_d;
			quad_q <= quad_d;
			sck_q <= sck_d;
			cs_q <= cs_d;
			rdy_q <= rdy_d;
			dn_q <= dn_d;
			left_q <= left_d;
			out_q <= out_d;
			div_q <= div_d;
			wait_q <= wait_d;
			sus_q <= sus_d;
			res_q <= res_d;
			oe_q <= oe_d;
		end
	end
	assign link.sck = sck_q;
	assign link.cs_b = cs_q;
	assign link.io_h = out_q;
	assign link.io_h_oe = oe_q;
	assign req_ready = rdy_q;
	assign done_pulse = dn_q;
endmodule // fmsp_host

/* dv/fmsp_chk.sv */
module fmsp_chk
	import fmsp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic cs_b,
	input wire logic [3:0] io_h,
	input wire logic [3:0] io_h_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic sck_q;
	logic [3:0] rise_q, rise_d;
	logic [6:0] gap_q, gap_d;
	// clock rises within a frame, idle cycles between frames
	always_comb
	begin
		rise_d = cs_b ? 4'h0 : rise_q + {3'h0, sck & ~sck_q};
		gap_d = !cs_b ? 7'h00 : (gap_q == 7'h7F ? gap_q : gap_q + 7'h01);
	end
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sck_q <= 1'b0;
			rise_q <= 4'h0;
			gap_q <= 7'h7F;
		end
		else
		begin
			sck_q <= sck;
			rise_q <= rise_d;
			gap_q <= gap_d;
		end
	end
	// link waveform properties
	sequence s_high;
		sck [*4] ##1 !sck;
	endsequence
	sequence s_open;
		$fell(cs_b) ##0 !sck;
	endsequence
	property p_sck_idle; cs_b |-> !sck; endproperty
	property p_sck_half; $rose(sck) |-> s_high; endproperty
	property p_io_stable; $rose(sck) |-> $stable(io_h); endproperty
	property p_host_drives; $rose(sck) |-> io_h_oe[0]; endproperty
	property p_cs_open; $fell(cs_b) |-> s_open; endproperty
	property p_frame_len; $fell(cs_b) |-> ##[8:100] $rose(cs_b); endproperty
	property p_frame_count; $rose(cs_b) |-> (rise_q == 4'h8 || rise_q == 4'h2); endproperty
	property p_cs_gap; $fell(cs_b) |-> gap_q >= RELEASE_RECOVERY_CYC; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock moves outside frame");
	a_sck_half: assert property (p_sck_half) else $error("clock high phase wrong");
	a_io_stable: assert property (p_io_stable) else $error("data moves at clock rise");
	a_host_drives: assert property (p_host_drives) else $error("data line undriven");
	a_cs_open: assert property (p_cs_open) else $error("frame opens with clock high");
	a_frame_len: assert property (p_frame_len) else $error("frame too long");
	a_frame_count: assert property (p_frame_count) else $error("frame bit count wrong");
	a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
endmodule // fmsp_chk

/* dv/fmsp_bench.sv */
module fmsp_bench
	import fmsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_b, req_valid, req_quad, req_ready, done_pulse, acc_v;
	logic qe, er, cer, pr, write_enable_latch, qmode, pdown;
	logic [2:0] req_op;
	logic [7:0] req_code, acc_cmd;
	logic [15:0] stat;
	int miscompares = 0;
	int compares = 0;
	int acc_cnt = 0;
	int wait_n = 0;
	localparam logic [7:0] OK_C [19] = '{8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
		8'h05, 8'hAB, 8'h9F, 8'h90, 8'h4B, 8'h5A, 8'hC0, 8'h02, 8'h32, 8'h06};
	localparam logic [7:0] BAD_C [6] = '{CMD_STATUS_WRITE, CMD_SECTOR_ERASE, CMD_BLOCK32_ERASE,
		CMD_BLOCK64_ERASE, CMD_CHIP_ERASE, CMD_CHIP_ERASE_ALT};
	fmsp_link_if link();
	fmsp_host fmsp_host_i (.core_clk(core_clk), .rst_b(rst_b), .link(link), .req_valid(req_valid),
		.req_op(req_op), .req_code(req_code), .req_quad(req_quad), .req_ready(req_ready),
		.done_pulse(done_pulse));
	fmsp_device fmsp_device_i (.core_clk(core_clk), .rst_b(rst_b), .link(link), .quad_enable_bit(qe),
		.erase_running(er), .chip_erase_running(cer), .program_running(pr), .write_enable_latch_in(write_enable_latch),
		.quad_peripheral_mode(qmode), .status_word(stat), .deep_powerdown(pdown), .suspend_pulse(),
		.resume_pulse(), .accepted_cmd(acc_cmd), .accepted_valid(acc_v));
	fmsp_chk fmsp_chk_i (.core_clk(core_clk), .rst_b(rst_b), .sck(link.sck), .cs_b(link.cs_b),
		.io_h(link.io_h), .io_h_oe(link.io_h_oe));
	// clock
	initial
	begin
		forever #25 core_clk = ~core_clk;
	end
	// count commands the device acted on
	always @(posedge core_clk)
	begin
		if (acc_v === 1'b1)
			acc_cnt <= acc_cnt + 1;
	end
	task automatic test_done;
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one framed command, then judge whether the device took it
	task automatic cmd(input fmsp_op_t op, input logic [7:0] code, input logic q, input logic acc);
		int base;
		int n;
		base = acc_cnt;
		n = 0;
		req_valid <= 1'b1;
		req_op <= op;
		req_code <= code;
		req_quad <= q;
		@(posedge core_clk);
		req_valid <= 1'b0;
		while (done_pulse !== 1'b1 && n < 4000)
		begin
			@(posedge core_clk);
			n++;
		end
		wait_n = n;
		if (n >= 4000)
		begin
			miscompares++;
			test_done;
		end
		else
		begin
			chk(16'(acc_cnt - base), {15'h0, acc});
			if (acc)
				chk({8'h0, acc_cmd}, {8'h0, code});
		end
	endtask
	task automatic sc_suspend;
		er <= 1'b1;
		write_enable_latch <= 1'b1;
		cyc(1);
		write_enable_latch <= 1'b0;
		cyc(2);
		chk(stat & 16'h0002, 16'h0002);
		cmd(FMSP_OP_SUSPEND, CMD_SUSPEND, 1'b0, 1'b1);
		er <= 1'b0;
		chk(16'(wait_n >= SUSPEND_CYC), 16'h0001);
		chk(stat & 16'h8402, 16'h8000);
		cmd(FMSP_OP_RAW, CMD_WRITE_ENABLE, 1'b0, 1'b1);
		cmd(FMSP_OP_RAW, CMD_STATUS_READ, 1'b0, 1'b1);
		cyc(SUSPEND_CYC);
		for (int i = 0; i < 6; i++)
			cmd(FMSP_OP_RAW, BAD_C[i], 1'b0, 1'b0);
		for (int i = 0; i < 19; i++)
			cmd(FMSP_OP_RAW, OK_C[i], 1'b0, 1'b1);
		pr <= 1'b1;
		cmd(FMSP_OP_SUSPEND, CMD_SUSPEND, 1'b0, 1'b1);
		pr <= 1'b0;
		chk(stat & 16'h8402, 16'h8400);
		cyc(SUSPEND_CYC);
		cmd(FMSP_OP_RAW, CMD_PAGE_PROGRAM, 1'b0, 1'b0);
		cmd(FMSP_OP_RAW, CMD_QUAD_PAGE_PROGRAM, 1'b0, 1'b0);
		cmd(FMSP_OP_RESUME, CMD_RESUME, 1'b0, 1'b1);
		chk(stat & 16'h8400, 16'h8000);
		chk(16'(wait_n >= RESUME_GAP_CYC), 16'h0001);
		cmd(FMSP_OP_RESUME, CMD_RESUME, 1'b0, 1'b1);
		chk(stat & 16'h8400, 16'h0000);
		er <= 1'b1;
		cyc(2);
		chk(stat & 16'h0001, 16'h0001);
		er <= 1'b0;
		cyc(2);
		chk(stat & 16'h0001, 16'h0000);
		write_enable_latch <= 1'b0;
	endtask
	task automatic sc_chip;
		cer <= 1'b1;
		cmd(FMSP_OP_SUSPEND, CMD_SUSPEND, 1'b0, 1'b0);
		chk(stat & 16'h8400, 16'h0000);
		cer <= 1'b0;
	endtask
	task automatic sc_quad;
		cmd(FMSP_OP_QUAD_ENTRY, CMD_QUAD_ENTRY, 1'b0, 1'b0);
		qe <= 1'b1;
		cmd(FMSP_OP_RAW, CMD_QUAD_ENTRY, 1'b1, 1'b0);
		cmd(FMSP_OP_QUAD_ENTRY, CMD_QUAD_ENTRY, 1'b0, 1'b1);
		chk({15'h0, qmode}, 16'h1);
		pr <= 1'b1;
		cmd(FMSP_OP_SUSPEND, CMD_SUSPEND, 1'b1, 1'b1);
		pr <= 1'b0;
		chk(stat & 16'h8400, 16'h0400);
		cyc(SUSPEND_CYC);
		cmd(FMSP_OP_RESUME, CMD_RESUME, 1'b1, 1'b1);
		chk(stat & 16'h8400, 16'h0000);
		cmd(FMSP_OP_RAW, CMD_QUAD_EXIT, 1'b0, 1'b0);
		cmd(FMSP_OP_QUAD_EXIT, CMD_QUAD_EXIT, 1'b1, 1'b1);
		chk({15'h0, qmode}, 16'h0);
	endtask
	task automatic sc_pdown;
		cmd(FMSP_OP_RAW, CMD_POWERDOWN, 1'b1, 1'b0);
		cmd(FMSP_OP_POWERDOWN, CMD_POWERDOWN, 1'b0, 1'b1);
		cyc(POWERDOWN_ENTRY_CYC);
		chk({15'h0, pdown}, 16'h1);
		cmd(FMSP_OP_RAW, CMD_STATUS_READ, 1'b0, 1'b0);
		cmd(FMSP_OP_RAW, CMD_WRITE_ENABLE, 1'b0, 1'b0);
		pr <= 1'b1;
		cmd(FMSP_OP_RELEASE, CMD_RELEASE, 1'b0, 1'b0);
		pr <= 1'b0;
		cmd(FMSP_OP_RELEASE, CMD_RELEASE, 1'b0, 1'b1);
		cyc(RELEASE_RECOVERY_CYC);
		chk({15'h0, pdown}, 16'h0);
		cmd(FMSP_OP_RAW, CMD_STATUS_READ, 1'b0, 1'b1);
	endtask
	// reset, then the scenarios
	initial
	begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_op = 3'h0;
		req_code = 8'h00;
		req_quad = 1'b0;
		{qe, er, cer, pr, write_enable_latch} = 5'h00;
		cyc(6);
		rst_b <= 1'b1;
		cyc(2);
		sc_suspend;
		sc_chip;
		sc_quad;
		sc_pdown;
		test_done;
	end
endmodule // fmsp_bench
